// ### rtl/cdg_clock_domains.sv
`timescale 1ns/1ps
module cdg_clock_domains (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cdg_pkg::cdg_src_s src_in,
    input wire cdg_pkg::cdg_valid_s valid_in,
    input wire logic logic_self_test,
    output logic bus_clock,
    output logic cpu_core_clock,
    output logic delayed_core_clock,
    output logic peripheral_clock_one,
    output logic encoder_clock,
    output logic peripheral_clock_two,
    output logic async_peripheral_clock,
    output logic os_timer_clock,
    output logic external_clock_output_pin,
    output logic timer_output_pin_two
);
    // ********************************
    // Input synchronisers
    // ********************************
    // Sources are sampled, so each must stay below half of pclk
    logic [8:0] sync1_r;
    logic [8:0] sync2_r;
    cdg_pkg::cdg_src_s src;
    cdg_pkg::cdg_valid_s vld;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
        end else if (clk_en) begin
            sync1_r <= {valid_in, src_in};
            sync2_r <= sync1_r;
        end
    end
    assign src = sync2_r[5:0];
    assign vld = sync2_r[8:6];

    // ********************************
    // Registers
    // ********************************
    logic [2:0] main_sel_r;
    logic [2:0] async_sel_r;
    logic [2:0] timer_sel_r;
    logic [1:0] timer_div_r;
    logic [2:0] selftest_div_r;
    logic [31:0] dis_r;
    logic [1:0] pdiv_one_r;
    logic [1:0] pdiv_two_r;
    logic [3:0] test_external_clock_output_pin_r;
    logic [3:0] test_pin2_r;
    logic test_en_r;
    localparam int NUM_DOM_L = cdg_pkg::NUM_DOM;
    logic [NUM_DOM_L-1:0] gate_r;
    logic [NUM_DOM_L-1:0] dom_r;

    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign pready = 1'b1;

    always_comb begin
        hit = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            cdg_pkg::MAIN_SEL_ADDR: prdata = {29'h0, main_sel_r};
            cdg_pkg::ASYNC_SEL_ADDR: prdata = {29'h0, async_sel_r};
            cdg_pkg::SELFTEST_DIV_ADDR: prdata = {29'h0, selftest_div_r};
            cdg_pkg::TIMER_SEL_ADDR: prdata = {22'h0, timer_div_r, 5'h0, timer_sel_r};
            cdg_pkg::DOMAIN_DIS_ADDR: prdata = dis_r;
            cdg_pkg::PERIPH_DIV_ADDR: prdata = {22'h0, pdiv_two_r, 6'h0, pdiv_one_r};
            cdg_pkg::CLOCK_TEST_ADDR: prdata = {7'h0, test_en_r, 12'h0, test_pin2_r,
                                                4'h0, test_external_clock_output_pin_r};
            cdg_pkg::STATUS_ADDR: prdata = {17'h0, gate_r, 1'b0, dom_r};
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = acc && (!hit || (pwrite && paddr == cdg_pkg::STATUS_ADDR));

    logic wr;
    assign wr = acc && pwrite && clk_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_sel_r <= cdg_pkg::MAIN_SEL_RST; // R1
            async_sel_r <= cdg_pkg::SUB_SEL_RST; // R1
            timer_sel_r <= cdg_pkg::SUB_SEL_RST; // R1
            timer_div_r <= 2'h0;
            selftest_div_r <= 3'h0;
            dis_r <= cdg_pkg::DOMAIN_DIS_RST;
            pdiv_one_r <= 2'h0;
            pdiv_two_r <= 2'h0;
            test_external_clock_output_pin_r <= 4'h0;
            test_pin2_r <= 4'h0;
            test_en_r <= 1'b0;
        end else if (wr) begin
            case (paddr)
                cdg_pkg::MAIN_SEL_ADDR: main_sel_r <= pwdata[2:0];
                cdg_pkg::ASYNC_SEL_ADDR: async_sel_r <= pwdata[2:0]; // R10
                cdg_pkg::SELFTEST_DIV_ADDR: selftest_div_r <= pwdata[2:0];
                cdg_pkg::TIMER_SEL_ADDR: begin
                    timer_sel_r <= pwdata[2:0];
                    timer_div_r <= pwdata[cdg_pkg::TIMER_DIV_LSB +: 2];
                end
                cdg_pkg::DOMAIN_DIS_ADDR: dis_r <= pwdata; // R18
                cdg_pkg::PERIPH_DIV_ADDR: begin
                    pdiv_one_r <= pwdata[1:0];
                    pdiv_two_r <= pwdata[cdg_pkg::PDIV_TWO_LSB +: 2];
                end
                cdg_pkg::CLOCK_TEST_ADDR: begin
                    test_external_clock_output_pin_r <= pwdata[3:0];
                    test_pin2_r <= pwdata[cdg_pkg::TEST_PIN2_LSB +: 4];
                    test_en_r <= pwdata[cdg_pkg::TEST_EN_BIT];
                end
                default: ;
            endcase
        end
    end

    // ********************************
    // Source selection
    // ********************************
    // Reserved codes fall back to the oscillator so a domain never stops dead
    function automatic logic pick(input logic [2:0] code, input cdg_pkg::cdg_src_s s,
                                  input logic p1);
        case (code)
            cdg_pkg::SRC_PLL: pick = s.pll;
            cdg_pkg::SRC_EXT: pick = s.ext;
            cdg_pkg::SRC_LF: pick = s.lf;
            cdg_pkg::SRC_HF: pick = s.hf;
            cdg_pkg::SRC_PCLK1: pick = p1;
            default: pick = s.osc; // R16
        endcase
    endfunction

    logic [2:0] req_sel [3];
    logic [2:0] act_r [3];
    logic [2:0] sel_lvl;
    assign req_sel[0] = main_sel_r;
    assign req_sel[1] = async_sel_r;
    assign req_sel[2] = timer_sel_r;

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_sel
            // Main domain cannot pick peripheral clock one, which it feeds
            logic [2:0] req;
            assign req = (k == 0 && req_sel[k] == cdg_pkg::SRC_PCLK1) ?
                         cdg_pkg::SRC_OSC : req_sel[k];
            assign sel_lvl[k] = pick(act_r[k], src, dom_r[cdg_pkg::D_P1]);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    act_r[k] <= (k == 0) ? cdg_pkg::MAIN_SEL_RST : cdg_pkg::SUB_SEL_RST;
                end else if (clk_en) begin
                    // Switch only while old and new source are both low
                    if (!sel_lvl[k] && !pick(req, src, dom_r[cdg_pkg::D_P1])) begin
                        act_r[k] <= req; // R17
                    end
                end
            end
        end
    endgenerate

    logic base_r;
    logic asy_r;
    logic tim_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_r <= 1'b0;
            asy_r <= 1'b0;
            tim_r <= 1'b0;
        end else if (clk_en) begin
            base_r <= sel_lvl[0];
            asy_r <= sel_lvl[1];
            tim_r <= sel_lvl[2];
        end
    end

    // ********************************
    // Pulse-swallow dividers
    // ********************************
    // Divider 0 cpu, 1 periph one, 2 periph two, 3 timer
    function automatic logic [3:0] plim(input logic [1:0] f);
        case (f)
            2'h0: plim = cdg_pkg::LIM_DIV1;
            2'h1: plim = cdg_pkg::LIM_DIV2;
            default: plim = cdg_pkg::LIM_DIV16; // R6
        endcase
    endfunction

    logic [3:0] lim [4];
    logic [3:0] div_in;
    logic [3:0] pass_r;
    logic [3:0] cnt_r [4];
    logic [3:0] prev_r;

    assign lim[0] = logic_self_test ? {1'b0, selftest_div_r} : cdg_pkg::LIM_DIV1; // R4 R5
    assign lim[1] = plim(pdiv_one_r);
    assign lim[2] = plim(pdiv_two_r);
    assign lim[3] = 4'((5'h01 << timer_div_r) - 5'h01);
    assign div_in = {tim_r, base_r, base_r, base_r};

    generate
        for (k = 0; k < 4; k++) begin : g_div
            // Decisions fall on the source falling edge, so a high phase is never cut
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_r[k] <= 4'h0;
                    pass_r[k] <= 1'b1;
                    prev_r[k] <= 1'b0;
                end else if (clk_en) begin
                    prev_r[k] <= div_in[k];
                    if (prev_r[k] && !div_in[k]) begin
                        if (cnt_r[k] >= lim[k]) begin
                            cnt_r[k] <= 4'h0;
                            pass_r[k] <= 1'b1; // R17
                        end else begin
                            cnt_r[k] <= cnt_r[k] + 4'h1;
                            pass_r[k] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ********************************
    // Domain gating
    // ********************************
    logic [NUM_DOM_L-1:0] raw;
    assign raw[cdg_pkg::D_BUS] = base_r;
    assign raw[cdg_pkg::D_CPU] = base_r & pass_r[0]; // R3
    assign raw[cdg_pkg::D_P1] = base_r & pass_r[1];
    assign raw[cdg_pkg::D_QEP] = base_r & pass_r[1]; // R7
    assign raw[cdg_pkg::D_P2] = base_r & pass_r[2];
    assign raw[cdg_pkg::D_ASY] = asy_r;
    assign raw[cdg_pkg::D_TIM] = tim_r & pass_r[3];

    generate
        for (k = 0; k < NUM_DOM_L; k++) begin : g_gate
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gate_r[k] <= 1'b1;
                    dom_r[k] <= 1'b0;
                end else if (clk_en) begin
                    // Gate moves only while the domain is low
                    if (!raw[k]) begin
                        gate_r[k] <= !dis_r[cdg_pkg::DIS_BIT[k]]; // R2 R3 R6 R9 R10 R12 R17
                    end
                    dom_r[k] <= raw[k] & gate_r[k]; // R18
                end
            end
        end
    endgenerate

    logic [cdg_pkg::DELAY_STAGES-1:0] dly_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r <= '0;
        end else if (clk_en) begin
            dly_r <= {dly_r[cdg_pkg::DELAY_STAGES-2:0], dom_r[cdg_pkg::D_CPU]}; // R5
        end
    end

    assign bus_clock = dom_r[cdg_pkg::D_BUS];
    assign cpu_core_clock = dom_r[cdg_pkg::D_CPU];
    assign delayed_core_clock = dly_r[cdg_pkg::DELAY_STAGES-1];
    assign peripheral_clock_one = dom_r[cdg_pkg::D_P1];
    assign encoder_clock = dom_r[cdg_pkg::D_QEP];
    assign peripheral_clock_two = dom_r[cdg_pkg::D_P2];
    assign async_peripheral_clock = dom_r[cdg_pkg::D_ASY];
    assign os_timer_clock = dom_r[cdg_pkg::D_TIM];

    // ********************************
    // Clock test outputs
    // ********************************
    logic external_clock_output_pin_r;
    logic pin2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_clock_output_pin_r <= 1'b0;
            pin2_r <= 1'b0;
        end else if (clk_en) begin
            external_clock_output_pin_r <= 1'b0;
            pin2_r <= 1'b0;
            if (test_en_r) begin // R13
                case (test_external_clock_output_pin_r) // R14
                    4'h0: external_clock_output_pin_r <= src.osc;
                    4'h1: external_clock_output_pin_r <= src.pll;
                    4'h4: external_clock_output_pin_r <= src.lf;
                    4'h5: external_clock_output_pin_r <= src.hf;
                    4'h8: external_clock_output_pin_r <= dom_r[cdg_pkg::D_CPU];
                    4'h9: external_clock_output_pin_r <= dom_r[cdg_pkg::D_TIM];
                    4'hb: external_clock_output_pin_r <= dom_r[cdg_pkg::D_ASY];
                    4'hf: external_clock_output_pin_r <= src.pump;
                    default: external_clock_output_pin_r <= 1'b0;
                endcase
                case (test_pin2_r) // R15
                    4'h0: pin2_r <= vld.osc_valid;
                    4'h1: pin2_r <= vld.pll_valid;
                    4'h5: pin2_r <= vld.hf_valid;
                    4'h8: pin2_r <= src.lf;
                    4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: pin2_r <= vld.osc_valid;
                    default: pin2_r <= 1'b0;
                endcase
            end
        end
    end
    assign external_clock_output_pin = external_clock_output_pin_r;
    assign timer_output_pin_two = pin2_r;

    // ********************************
    // Checks
    // ********************************
    AST_BUS_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R2
        clk_en && dis_r[1] && !base_r
        ##1 (clk_en && dis_r[1])[*2] |-> ##1 !bus_clock)
        else $error("bus clock runs while disabled");
    AST_CPU_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R3
        clk_en && dis_r[0] && !raw[cdg_pkg::D_CPU]
        ##1 (clk_en && dis_r[0])[*2] |-> ##1 !cpu_core_clock)
        else $error("cpu clock runs while disabled");
    AST_CPU_IN_PHASE: assert property (@(posedge pclk) disable iff (!presetn) // R3
        clk_en && gate_r[cdg_pkg::D_BUS] |=> !cpu_core_clock || bus_clock)
        else $error("cpu clock high without bus clock");
    AST_DELAY_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R5
        clk_en[*3] |-> delayed_core_clock == $past(cpu_core_clock, 2))
        else $error("delayed clock not two cycles behind");
    AST_P1_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R6
        clk_en && dis_r[2] && !raw[cdg_pkg::D_P1]
        ##1 (clk_en && dis_r[2])[*2] |-> ##1 !peripheral_clock_one)
        else $error("peripheral clock one runs while disabled");
    AST_QEP_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R7
        clk_en && dis_r[9] && !raw[cdg_pkg::D_QEP]
        ##1 (clk_en && dis_r[9])[*2] |-> ##1 !encoder_clock)
        else $error("encoder clock runs while disabled");
    AST_P2_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R9
        clk_en && dis_r[3] && !raw[cdg_pkg::D_P2]
        ##1 (clk_en && dis_r[3])[*2] |-> ##1 !peripheral_clock_two)
        else $error("peripheral clock two runs while disabled");
    AST_ASY_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R10
        clk_en && dis_r[4] && !asy_r
        ##1 (clk_en && dis_r[4])[*2] |-> ##1 !async_peripheral_clock)
        else $error("async clock runs while disabled");
    AST_TIM_GATED: assert property (@(posedge pclk) disable iff (!presetn) // R12
        clk_en && dis_r[6] && !raw[cdg_pkg::D_TIM]
        ##1 (clk_en && dis_r[6])[*2] |-> ##1 !os_timer_clock)
        else $error("timer clock runs while disabled");
    AST_NO_RUNT: assert property (@(posedge pclk) disable iff (!presetn) // R17
        clk_en && bus_clock && base_r |=> !clk_en || cpu_core_clock == $past(cpu_core_clock))
        else $error("cpu clock pulse cut short");
    AST_TEST_OFF: assert property (@(posedge pclk) disable iff (!presetn) // R13
        clk_en && !test_en_r |=> !external_clock_output_pin && !timer_output_pin_two)
        else $error("test pins driven outside test mode");
    AST_PIN2_VALID: assert property (@(posedge pclk) disable iff (!presetn) // R15
        clk_en && test_en_r && test_pin2_r >= 4'h9 |=> timer_output_pin_two == $past(vld.osc_valid))
        else $error("pin two does not show oscillator valid");
endmodule

// ### include/cdg_pkg.sv
// Notes on behaviour
// [R1] After reset main domains use oscillator; async and timer use peripheral clock one.
// [R2] Disable bit 1 gates the bus clock off.
// [R3] Processor clock equals bus clock in phase; disable bit 0 gates it.
// [R4] During self-test the processor clock divides by 1 to 8 from divider field.
// [R5] Delayed processor clock lags two cycles, gated and divided with processor clock.
// [R6] Peripheral clock one is bus clock over 1, 2 or 16; disable bit 2.
// [R7] Encoder copy of peripheral clock one is gated by disable bit 9.
// [R8] Software keeps peripheral clock two an integer multiple of clock one.
// [R9] Peripheral clock two is gated by disable bit 3.
// [R10] Async peripheral clock has its own select, up to bus rate, bit 4.
// [R11] Software keeps a foreign timer source at most a third of clock one.
// [R12] Disable bit 6 gates the OS-timer clock off.
// [R13] Clock-test mode routes chosen clocks or status to two output pins.
// [R14] Test field bits 3:0 choose the external clock pin signal.
// [R15] Test field bits 11:8 choose the timer pin two signal.
// [R16] Source numbers: 0 oscillator, 1 PLL, 3 external, 4 low ref, 5 high ref.
// [R17] Gating, source and divider changes never shorten a domain clock pulse.
// [R18] A set disable bit holds its domain clock low until cleared.
package cdg_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [31:0] MAIN_SEL_ADDR = 32'hffffe100;
    localparam logic [31:0] ASYNC_SEL_ADDR = 32'hffffe104;
    localparam logic [31:0] SELFTEST_DIV_ADDR = 32'hffffe108;
    localparam logic [31:0] TIMER_SEL_ADDR = 32'hffffe10c;
    localparam logic [31:0] DOMAIN_DIS_ADDR = 32'hffffe110;
    localparam logic [31:0] PERIPH_DIV_ADDR = 32'hffffe114;
    localparam logic [31:0] CLOCK_TEST_ADDR = 32'hffffe118;
    localparam logic [31:0] STATUS_ADDR = 32'hffffe11c;

    // ********************************
    // Source codes and reset values
    // ********************************
    localparam logic [2:0] SRC_OSC = 3'h0;
    localparam logic [2:0] SRC_PLL = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h3;
    localparam logic [2:0] SRC_LF = 3'h4;
    localparam logic [2:0] SRC_HF = 3'h5;
    localparam logic [2:0] SRC_PCLK1 = 3'h6;
    localparam logic [2:0] MAIN_SEL_RST = SRC_OSC;
    localparam logic [2:0] SUB_SEL_RST = SRC_PCLK1;
    localparam logic [31:0] DOMAIN_DIS_RST = 32'h00000000;

    // ********************************
    // Field positions
    // ********************************
    localparam int TIMER_DIV_LSB = 8;
    localparam int PDIV_TWO_LSB = 8;
    localparam int TEST_PIN2_LSB = 8;
    localparam int TEST_EN_BIT = 24;

    // Domain order: bus, cpu, periph one, encoder, periph two, async, timer
    localparam int NUM_DOM = 7;
    localparam int D_BUS = 0;
    localparam int D_CPU = 1;
    localparam int D_P1 = 2;
    localparam int D_QEP = 3;
    localparam int D_P2 = 4;
    localparam int D_ASY = 5;
    localparam int D_TIM = 6;
    localparam logic [4:0] DIS_BIT [NUM_DOM] = '{5'h1, 5'h0, 5'h2, 5'h9, 5'h3, 5'h4, 5'h6};

    // Divider counts
    localparam logic [3:0] LIM_DIV1 = 4'h0;
    localparam logic [3:0] LIM_DIV2 = 4'h1;
    localparam logic [3:0] LIM_DIV16 = 4'hf;
    localparam int DELAY_STAGES = 2;

    typedef struct packed {
        logic pump;
        logic hf;
        logic lf;
        logic ext;
        logic pll;
        logic osc;
    } cdg_src_s;

    typedef struct packed {
        logic hf_valid;
        logic pll_valid;
        logic osc_valid;
    } cdg_valid_s;
endpackage

// ### testbench/cdg_clock_domains_tb.sv
`timescale 1ns/1ps
module cdg_clock_domains_tb;
    typedef struct {
        logic [7:0] off;
        logic [31:0] wd;
        logic [31:0] rd;
        int mon;
        int rs;
        int lvl;
    } cdg_row_s;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cdg_pkg::cdg_src_s src_in = '0;
    cdg_pkg::cdg_valid_s valid_in = 3'h5;
    logic logic_self_test = 1'b0;
    logic [9:0] outs;
    logic [1:0] cpu_hist = 2'h0;
    logic dl_on = 1'b0;
    logic ph_on = 1'b0;
    logic [31:0] rd;
    logic err;
    int n;
    int cyc = 0;
    int hi_len [8] = '{default: 0};
    int fail_count = 0;
    int num_checks = 0;

    // ********************************
    // Rows: offset, write, readback, watched output, rises in 240 cycles, level
    // ********************************
    // Outputs: 0 bus 1 cpu 2 p1 3 enc 4 p2 5 async 6 timer 7 delayed 8 ext pin 9 pin two
    cdg_row_s rows [32] = '{
        '{8'h00, 32'h1, 32'h1, 0, 40, -1},
        '{8'h00, 32'h3, 32'h3, 0, 24, -1},
        '{8'h00, 32'h4, 32'h4, 0, 17, -1},
        '{8'h00, 32'h5, 32'h5, 0, 20, -1},
        '{8'h00, 32'h2, 32'h2, 0, 30, -1},
        '{8'h00, 32'hfffffff8, 32'h0, 1, 30, -1},
        '{8'h14, 32'h1, 32'h1, 2, 15, -1},
        '{8'h14, 32'h3, 32'h3, 2, 2, -1},
        '{8'h14, 32'h101, 32'h101, 4, 15, -1},
        '{8'h14, 32'h1, 32'h1, 4, 30, -1},
        '{8'h14, 32'h0, 32'h0, 3, 30, -1},
        '{8'h04, 32'h1, 32'h1, 5, 40, -1},
        '{8'h04, 32'h6, 32'h6, 5, 30, -1},
        '{8'h0c, 32'h200, 32'h200, 6, 8, -1},
        '{8'h0c, 32'h6, 32'h6, 6, 30, -1},
        '{8'h18, 32'h1000000, 32'h1000000, 8, 30, -1},
        '{8'h18, 32'h1000001, 32'h1000001, 8, 40, -1},
        '{8'h18, 32'h1000004, 32'h1000004, 8, 17, -1},
        '{8'h18, 32'h1000005, 32'h1000005, 8, 20, -1},
        '{8'h18, 32'h1000008, 32'h1000008, 8, 30, -1},
        '{8'h18, 32'h1000009, 32'h1000009, 8, 30, -1},
        '{8'h18, 32'h100000b, 32'h100000b, 8, 30, -1},
        '{8'h18, 32'h100000f, 32'h100000f, 8, 12, -1},
        '{8'h18, 32'h1000002, 32'h1000002, 8, 0, 0},
        '{8'h18, 32'h1000000, 32'h1000000, 9, 0, 1},
        '{8'h18, 32'h1000100, 32'h1000100, 9, 0, 0},
        '{8'h18, 32'h1000500, 32'h1000500, 9, 0, 1},
        '{8'h18, 32'h1000800, 32'h1000800, 9, 17, -1},
        '{8'h18, 32'h1000c00, 32'h1000c00, 9, 0, 1},
        '{8'h18, 32'h1000400, 32'h1000400, 9, 0, 0},
        '{8'h18, 32'hffffffff, 32'h1000f0f, 9, 0, 1},
        '{8'h18, 32'h800, 32'h800, 9, 0, 0}
    };

    cdg_clock_domains uut (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .src_in(src_in),
        .valid_in(valid_in),
        .logic_self_test(logic_self_test),
        .bus_clock(outs[0]),
        .cpu_core_clock(outs[1]),
        .delayed_core_clock(outs[7]),
        .peripheral_clock_one(outs[2]),
        .encoder_clock(outs[3]),
        .peripheral_clock_two(outs[4]),
        .async_peripheral_clock(outs[5]),
        .os_timer_clock(outs[6]),
        .external_clock_output_pin(outs[8]),
        .timer_output_pin_two(outs[9])
    );

    always #4 pclk = ~pclk;

    // Sources stay well below half the bus rate so the synchronisers see every edge
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        src_in <= {cyc % 20 < 10, cyc % 12 < 6, cyc % 14 < 7, cyc % 10 < 5, cyc % 6 < 3,
                   cyc % 8 < 4};
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got,
                       input int tol);
        num_checks++;
        if (got !== exp && (tol == 0 || got > exp + tol || got + tol < exp)) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Settle past source and divider hand-over, then count rising levels
    task automatic rises(input int idx, output int r);
        logic prev;
        r = 0;
        repeat (40) @(posedge pclk);
        prev = outs[idx];
        repeat (240) begin
            @(posedge pclk);
            if (outs[idx] === 1'b1 && prev === 1'b0) r++;
            prev = outs[idx];
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ********************************
    // Continuous monitors
    // ********************************
    always @(posedge pclk) begin
        cpu_hist <= {cpu_hist[0], outs[1]};
        if (dl_on) begin
            chk("delayed_cpu", {31'h0, cpu_hist[1]}, {31'h0, outs[7]}, 0);
            for (int i = 0; i < 8; i++) begin
                if (outs[i] === 1'b1) begin
                    hi_len[i] <= hi_len[i] + 1;
                end else begin
                    if (hi_len[i] > 0 && hi_len[i] < 3) chk("short_high", 3, hi_len[i], 0);
                    hi_len[i] <= 0;
                end
            end
        end
        if (ph_on) chk("cpu_phase", {31'h0, outs[0]}, {31'h0, outs[1]}, 0);
    end

    initial begin
        #400000;
        fail_count++;
        $display("[ERR] watchdog expected done seen hang");
        close_out();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        #18;
        chk("reset_outs", 32'h0, {22'h0, outs}, 0);
        chk("reset_ready", 32'h1, {31'h0, pready}, 0);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        dl_on <= 1'b1;
        @(posedge pclk);
        apb(1'b0, cdg_pkg::MAIN_SEL_ADDR, 32'h0, rd, err);
        chk("main_sel_rst", {29'h0, cdg_pkg::MAIN_SEL_RST}, rd, 0);
        apb(1'b0, cdg_pkg::ASYNC_SEL_ADDR, 32'h0, rd, err);
        chk("async_sel_rst", {29'h0, cdg_pkg::SUB_SEL_RST}, rd, 0);
        apb(1'b0, cdg_pkg::TIMER_SEL_ADDR, 32'h0, rd, err);
        chk("timer_sel_rst", {29'h0, cdg_pkg::SUB_SEL_RST}, rd, 0);
        apb(1'b0, cdg_pkg::DOMAIN_DIS_ADDR, 32'h0, rd, err);
        chk("dis_rst", cdg_pkg::DOMAIN_DIS_RST, rd, 0);
        for (int d = 0; d < 7; d++) begin
            rises(d, n);
            chk("default_rises", 30, n, 1);
        end
        ph_on <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, cdg_pkg::MAIN_SEL_ADDR + rows[i].off, rows[i].wd, rd, err);
            chk("wr_err", 32'h0, {31'h0, err}, 0);
            apb(1'b0, cdg_pkg::MAIN_SEL_ADDR + rows[i].off, 32'h0, rd, err);
            chk("readback", rows[i].rd, rd, 0);
            rises(rows[i].mon, n);
            chk("rises", rows[i].rs, n, 1);
            if (rows[i].lvl >= 0) chk("level", rows[i].lvl, {31'h0, outs[rows[i].mon]}, 0);
        end
        ph_on <= 1'b0;
        for (int d = 0; d < cdg_pkg::NUM_DOM; d++) begin
            apb(1'b1, cdg_pkg::DOMAIN_DIS_ADDR, 32'h1 << cdg_pkg::DIS_BIT[d], rd, err);
            rises(d, n);
            chk("gated_rises", 32'h0, n, 0);
            chk("gated_level", 32'h0, {31'h0, outs[d]}, 0);
            apb(1'b0, cdg_pkg::STATUS_ADDR, 32'h0, rd, err);
            chk("status_gate", 32'h0, {31'h0, rd[8 + d]}, 0);
            chk("status_level", 32'h0, {31'h0, rd[d]}, 0);
            if (d == cdg_pkg::D_CPU) chk("gated_dly", 32'h0, {31'h0, outs[7]}, 0);
            if (d == cdg_pkg::D_BUS) begin
                rises(1, n);
                chk("cpu_while_bus_off", 30, n, 1);
            end
            apb(1'b1, cdg_pkg::DOMAIN_DIS_ADDR, 32'h0, rd, err);
            rises(d, n);
            chk("ungated_rises", 30, n, 1);
        end
        logic_self_test <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, cdg_pkg::SELFTEST_DIV_ADDR, f, rd, err);
            rises(1, n);
            chk("selftest_cpu", (30 + (f + 1) / 2) / (f + 1), n, 1);
            rises(7, n);
            chk("selftest_dly", (30 + (f + 1) / 2) / (f + 1), n, 1);
        end
        logic_self_test <= 1'b0;
        apb(1'b1, cdg_pkg::STATUS_ADDR, 32'hffffffff, rd, err);
        chk("status_wr_err", 32'h1, {31'h0, err}, 0);
        apb(1'b0, cdg_pkg::STATUS_ADDR + 32'h4, 32'h0, rd, err);
        chk("unmapped_err", 32'h1, {31'h0, err}, 0);
        chk("unmapped_rd", 32'h0, rd, 0);
        dl_on <= 1'b0;
        clk_en <= 1'b0;
        apb(1'b1, cdg_pkg::MAIN_SEL_ADDR, 32'h1, rd, err);
        clk_en <= 1'b1;
        apb(1'b0, cdg_pkg::MAIN_SEL_ADDR, 32'h0, rd, err);
        chk("frozen_wr", 32'h0, rd, 0);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("rerst_outs", 32'h0, {22'h0, outs}, 0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, cdg_pkg::SELFTEST_DIV_ADDR, 32'h0, rd, err);
        chk("rerst_div", 32'h0, rd, 0);
        rises(0, n);
        chk("rerst_rises", 30, n, 1);
        close_out();
    end
endmodule
